// ==== src/snm_pkg.sv ====
// shared constants and types for the serial nonvolatile memory command logic
package snm_pkg;
  localparam int unsigned ADDR_W   = 14;
  localparam int unsigned DEPTH    = 16384;
  // opcodes
  localparam logic [7:0] OP_SET_LATCH = 8'h06;
  localparam logic [7:0] OP_CLR_LATCH = 8'h04;
  localparam logic [7:0] OP_SR_READ   = 8'h05;
  localparam logic [7:0] OP_SR_WRITE  = 8'h01;
  localparam logic [7:0] OP_MEM_READ  = 8'h03;
  localparam logic [7:0] OP_MEM_WRITE = 8'h02;
  localparam logic [7:0] OP_ID_READ   = 8'h9f;
  localparam logic [7:0] OP_SLEEP     = 8'hb9;
  // status register layout
  localparam int unsigned SB_STATUS_WRITE_PROTECT_ENABLE     = 7;
  localparam int unsigned SB_BP_HIGH  = 3;
  localparam int unsigned SB_BP_LOW   = 2;
  localparam logic [7:0]  SR_NV_MASK  = 8'hfc;
  localparam logic [7:0]  SR_RST      = 8'h00;
  // block protect bases
  localparam logic [ADDR_W-1:0] BP_QUARTER_BASE = 14'h3000;
  localparam logic [ADDR_W-1:0] BP_HALF_BASE    = 14'h2000;
  // serial bit counts
  localparam logic [4:0] BYTE_LAST = 5'h07;
  localparam logic [4:0] ADDR_LAST = 5'h0f;
  localparam logic [5:0] ID_BITS   = 6'h20;
  // sleep recovery: longest time, rounded down, less the pin synchroniser lag
  localparam int unsigned SLEEP_RECOVERY_US = 400;
  localparam int unsigned CLK_MHZ           = 10;
  localparam int unsigned SYNC_LAG          = 3;
  localparam int unsigned REC_CYC = SLEEP_RECOVERY_US * CLK_MHZ - SYNC_LAG;
  localparam logic [11:0] REC_LAST = 12'(REC_CYC - 1);
  localparam logic [11:0] REC_START = 12'h001;

  typedef enum logic [3:0] {
    ST_IDLE, ST_OPC, ST_RADDR, ST_WADDR, ST_WDATA, ST_SRIN,
    ST_RDOUT, ST_SROUT, ST_IDOUT, ST_SLPARM, ST_IGNORE
  } snm_state_t;

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic wp_n;
  } snm_pins_t;
endpackage

// ==== src/snm_cmd.sv ====
// serial memory command logic: opcode decode, status, array, id and sleep
// Operation
// - first eight bits after select are the opcode; eight commands decoded
// - select rising before eight opcode bits executes nothing
// - set-latch opcode sets the write enable latch
// - clear-latch opcode clears latch; cleared latch blocks status and array writes
// - latch clears at reset and on clear-latch; survives deselect after writes
// - status read shifts eight status bits out on falling clock edges
// - further clocks during status read repeat the status byte
// - status write takes one byte; bits 1 and 0 ignored
// - status bit7 protect enable, 6..4 spare, 3..2 block protect, 1 latch, 0 zero
// - array read takes 16 address bits, top two ignored, shifts byte msb first
// - further read bytes increment address, wrapping to zero without limit
// - array write commits each byte once its eight bits arrive
// - further write bytes go to incrementing wrapping addresses until deselect
// - id read shifts a 32-bit identifier out, input ignored
// - after the last id bit the output holds that bit until deselect
// - sleep opcode sleeps at deselect; any clock pulse in between cancels
// - asleep: clock and input ignored, output high impedance
// - wake no later than 400 us after select falls
// - block protect 01 upper quarter, 10 upper half, 11 whole array
// - input sampled on rising clock, output changed on falling clock
// - deselected: inputs ignored, output high impedance
// - protect enable with pin low locks status; protected blocks reject writes
`timescale 1ns/100ps
module snm_cmd #(
  parameter logic [7:0] ID_MAKER = 8'h5a,  // arbitrary value
  parameter logic [7:0] ID_CONT  = 8'h7f,  // arbitrary value
  parameter logic [7:0] ID_PROD1 = 8'h3c,  // arbitrary value
  parameter logic [7:0] ID_PROD2 = 8'hc3   // arbitrary value
) (
  input  wire logic sys_clk_i,
  input  wire logic sys_rst_i,
  input  wire logic spi_cs_n_i,
  input  wire logic spi_sck_i,
  input  wire logic spi_si_i,
  input  wire logic spi_wp_n_i,
  output logic      spi_so_o,
  output logic      spi_so_oe_n_o,
  output logic      asleep_o
);
  localparam int unsigned AW = snm_pkg::ADDR_W;

  snm_pkg::snm_pins_t  pin_s1_q, pin_s2_q;
  logic                sck_prev_q, cs_prev_q;
  snm_pkg::snm_state_t state_q, state_d;
  logic [4:0]          cnt_q, cnt_d;
  logic [7:0]          sh_q, sh_d;
  logic [AW-1:0]       addr_q, addr_d;
  logic [5:0]          obit_q, obit_d;
  logic [7:0]          sr_q, sr_d;
  logic                wel_q, wel_d;
  logic                so_q, so_d;
  logic                oe_n_q;
  logic                asleep_q, asleep_d;
  logic [11:0]         rec_q, rec_d;
  logic                mem_we;
  logic [7:0]          mem_q [snm_pkg::DEPTH];

  function automatic logic is_out(input snm_pkg::snm_state_t s);
    return (s == snm_pkg::ST_RDOUT) || (s == snm_pkg::ST_SROUT) ||
           (s == snm_pkg::ST_IDOUT);
  endfunction

  function automatic logic prot(input logic [1:0] bp, input logic [AW-1:0] a);
    unique case (bp)
      2'b00:   return 1'b0;
      2'b01:   return a >= snm_pkg::BP_QUARTER_BASE;
      2'b10:   return a >= snm_pkg::BP_HALF_BASE;
      default: return 1'b1;
    endcase
  endfunction

  // edges taken from the second synchroniser stage only
  wire       cs_low    = ~pin_s2_q.cs_n;
  wire       cs_fall   = cs_low & cs_prev_q;
  wire       cs_rise   = pin_s2_q.cs_n & ~cs_prev_q;
  wire       sck_rise  = pin_s2_q.sck & ~sck_prev_q;
  wire       sck_fall  = ~pin_s2_q.sck & sck_prev_q;
  wire [7:0] in_byte   = {sh_q[6:0], pin_s2_q.si};
  wire       byte_end  = (cnt_q == snm_pkg::BYTE_LAST);
  wire [7:0] sr_rd     = {sr_q[7:2], wel_q, 1'b0};
  wire [1:0] bp        = {sr_q[snm_pkg::SB_BP_HIGH], sr_q[snm_pkg::SB_BP_LOW]};
  wire       sr_locked = sr_q[snm_pkg::SB_STATUS_WRITE_PROTECT_ENABLE] & ~pin_s2_q.wp_n;
  wire       mem_ok    = wel_q & ~prot(bp, addr_q);
  wire       sr_ok     = wel_q & ~sr_locked;
  wire [31:0] id_word  = {ID_MAKER, ID_CONT, ID_PROD1, ID_PROD2};
  wire [7:0] rd_byte   = (state_q == snm_pkg::ST_SROUT) ? sr_rd : mem_q[addr_q];
  wire       so_pick   = (state_q == snm_pkg::ST_IDOUT) ? id_word[~obit_q[4:0]]
                                                        : rd_byte[~obit_q[2:0]];
  wire       oe_n_d    = asleep_q | ~is_out(state_q);

  always_comb begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    sh_d     = sh_q;
    addr_d   = addr_q;
    obit_d   = obit_q;
    sr_d     = sr_q;
    wel_d    = wel_q;
    so_d     = so_q;
    asleep_d = asleep_q;
    rec_d    = rec_q;
    mem_we   = 1'b0;
    if (asleep_q) begin
      if (rec_q == snm_pkg::REC_LAST) begin
        asleep_d = 1'b0;
        rec_d    = '0;
        state_d  = cs_low ? snm_pkg::ST_IGNORE : snm_pkg::ST_IDLE;
      end else if (rec_q != '0) begin
        rec_d = rec_q + 12'h001;
      end else if (cs_fall) begin
        rec_d = snm_pkg::REC_START;
      end
    end else if (cs_rise) begin
      // deselect aborts command, sleep taken here
      state_d = snm_pkg::ST_IDLE;
      if (state_q == snm_pkg::ST_SLPARM) asleep_d = 1'b1;
    end else if (cs_fall) begin
      state_d = snm_pkg::ST_OPC;
      cnt_d   = '0;
    end else if (cs_low) begin
      unique case (state_q)
        snm_pkg::ST_OPC: if (sck_rise) begin
          sh_d  = in_byte;
          cnt_d = cnt_q + 5'h01;
          if (byte_end) begin
            cnt_d  = '0;
            obit_d = '0;
            unique case (in_byte)
              snm_pkg::OP_SET_LATCH: begin
                wel_d   = 1'b1;
                state_d = snm_pkg::ST_IGNORE;
              end
              snm_pkg::OP_CLR_LATCH: begin
                wel_d   = 1'b0;
                state_d = snm_pkg::ST_IGNORE;
              end
              snm_pkg::OP_SR_READ:   state_d = snm_pkg::ST_SROUT;
              snm_pkg::OP_SR_WRITE:  state_d = snm_pkg::ST_SRIN;
              snm_pkg::OP_MEM_READ:  state_d = snm_pkg::ST_RADDR;
              snm_pkg::OP_MEM_WRITE: state_d = snm_pkg::ST_WADDR;
              snm_pkg::OP_ID_READ:   state_d = snm_pkg::ST_IDOUT;
              snm_pkg::OP_SLEEP:     state_d = snm_pkg::ST_SLPARM;
              default:               state_d = snm_pkg::ST_IGNORE;
            endcase
          end
        end
        snm_pkg::ST_RADDR, snm_pkg::ST_WADDR: if (sck_rise) begin
          // top address bits fall off the end
          addr_d = {addr_q[AW-2:0], pin_s2_q.si};
          cnt_d  = cnt_q + 5'h01;
          if (cnt_q == snm_pkg::ADDR_LAST) begin
            cnt_d   = '0;
            state_d = (state_q == snm_pkg::ST_RADDR) ? snm_pkg::ST_RDOUT
                                                     : snm_pkg::ST_WDATA;
          end
        end
        snm_pkg::ST_WDATA: if (sck_rise) begin
          sh_d  = in_byte;
          cnt_d = cnt_q + 5'h01;
          if (byte_end) begin
            cnt_d = '0;
            // commit per byte, gated by latch and protection
            mem_we = mem_ok;
            addr_d = addr_q + 14'h0001;
          end
        end
        snm_pkg::ST_SRIN: if (sck_rise) begin
          sh_d  = in_byte;
          cnt_d = cnt_q + 5'h01;
          if (byte_end) begin
            if (sr_ok) sr_d = in_byte & snm_pkg::SR_NV_MASK;
            state_d = snm_pkg::ST_IGNORE;
          end
        end
        snm_pkg::ST_RDOUT, snm_pkg::ST_SROUT: if (sck_fall) begin
          // shift out on falling edge, status repeats
          so_d   = so_pick;
          obit_d = obit_q + 6'h01;
          // next address after each byte, wrapping
          if (state_q == snm_pkg::ST_RDOUT && obit_q[2:0] == 3'h7)
            addr_d = addr_q + 14'h0001;
        end
        snm_pkg::ST_IDOUT: if (sck_fall && obit_q != snm_pkg::ID_BITS) begin
          // 32 bits out, last bit then held
          so_d   = so_pick;
          obit_d = obit_q + 6'h01;
        end
        snm_pkg::ST_SLPARM: if (sck_rise) state_d = snm_pkg::ST_IGNORE;
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    pin_s1_q <= {spi_cs_n_i, spi_sck_i, spi_si_i, spi_wp_n_i};
    pin_s2_q <= pin_s1_q;
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      sck_prev_q <= 1'b0;
      cs_prev_q  <= 1'b1;
      state_q    <= snm_pkg::ST_IDLE;
      cnt_q      <= '0;
      sh_q       <= '0;
      addr_q     <= '0;
      obit_q     <= '0;
      sr_q       <= snm_pkg::SR_RST;
      wel_q      <= 1'b0;
      so_q       <= 1'b0;
      oe_n_q     <= 1'b1;
      asleep_q   <= 1'b0;
      rec_q      <= '0;
    end else begin
      sck_prev_q <= pin_s2_q.sck;
      cs_prev_q  <= pin_s2_q.cs_n;
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      sh_q       <= sh_d;
      addr_q     <= addr_d;
      obit_q     <= obit_d;
      sr_q       <= sr_d;
      wel_q      <= wel_d;
      so_q       <= so_d;
      oe_n_q     <= oe_n_d;
      asleep_q   <= asleep_d;
      rec_q      <= rec_d;
    end
  end

  // array is not reset: it models nonvolatile storage
  always_ff @(posedge sys_clk_i) begin
    if (mem_we) mem_q[addr_q] <= in_byte;
  end

  assign spi_so_o      = so_q;
  assign spi_so_oe_n_o = oe_n_q;
  assign asleep_o      = asleep_q;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_sleep_cancel;
    state_q == snm_pkg::ST_SLPARM && cs_low && !cs_fall && sck_rise;
  endsequence
  sequence s_stay_awake;
    state_q == snm_pkg::ST_IGNORE ##1 !asleep_q [*2];
  endsequence

  chk_deselect_hiz: assert property (
    pin_s2_q.cs_n && $past(pin_s2_q.cs_n) |=> spi_so_oe_n_o)
    else $error("output driven while deselected");
  chk_latch_set: assert property (
    state_q == snm_pkg::ST_OPC && cs_low && !cs_fall && !asleep_q && sck_rise &&
    byte_end && in_byte == snm_pkg::OP_SET_LATCH |=> wel_q)
    else $error("latch not set");
  chk_latch_clear: assert property (
    state_q == snm_pkg::ST_OPC && cs_low && !cs_fall && !asleep_q && sck_rise &&
    byte_end && in_byte == snm_pkg::OP_CLR_LATCH |=> !wel_q)
    else $error("latch not cleared");
  chk_status_gate: assert property (
    !wel_q && !asleep_q |=> $stable(sr_q))
    else $error("status written without latch");
  chk_array_prot: assert property (
    mem_we |-> wel_q && !prot(bp, addr_q) && state_q == snm_pkg::ST_WDATA)
    else $error("write into protected block");
  chk_bit0_zero: assert property (
    sr_rd[0] == 1'b0 && sr_q[1:0] == 2'b00)
    else $error("status low bits not zero");
  chk_sleep_hiz: assert property (
    asleep_q |=> spi_so_oe_n_o && $stable(wel_q) && $stable(sr_q))
    else $error("activity while asleep");
  chk_wake_time: assert property (
    $fell(asleep_q) |-> $past(rec_q) == snm_pkg::REC_LAST)
    else $error("wake time wrong");
  chk_opc_abort: assert property (
    state_q == snm_pkg::ST_OPC && cs_rise && !asleep_q |=>
      state_q == snm_pkg::ST_IDLE && $stable(wel_q) && !asleep_q)
    else $error("aborted opcode had effect");
  chk_sleep_cancel: assert property (
    s_sleep_cancel |=> s_stay_awake)
    else $error("sleep not cancelled by clock");
  chk_read_incr: assert property (
    state_q == snm_pkg::ST_RDOUT && cs_low && !cs_fall && !cs_rise && !asleep_q &&
    sck_fall && obit_q[2:0] == 3'h7 |=> addr_q == $past(addr_q) + 14'h0001)
    else $error("read address not advanced");
endmodule

// ==== verif/snm_host.sv ====
// spi host model: drives select, clock, data and protect pin in mode 0 or mode 3
`timescale 1ns/100ps
module snm_host (
  input  wire logic          sys_clk_i,
  input  wire logic          so_i,
  input  wire logic          so_oe_n_i,
  output snm_pkg::snm_pins_t pins_o
);
  logic so_last_q = 1'b0;
  logic sck_idle  = 1'b0;
  logic so_w;
  // a released line toggles so a stale bit can never pass for data
  assign so_w = so_oe_n_i ? ~so_last_q : so_i;
  always_ff @(posedge sys_clk_i) so_last_q <= so_w;
  initial pins_o = 4'h9;
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  // idle clock level: low for mode 0, high for mode 3
  task automatic set_mode(input logic m3);
    sck_idle = m3;
    pins_o.sck = m3;
    tick(4);
  endtask
  // protect pin level, changed only between commands
  task automatic set_wp(input logic v);
    pins_o.wp_n = v;
  endtask
  task automatic sel();
    pins_o.cs_n = 1'b0;
    tick(4);
  endtask
  // set data low, read before fall
  task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      pins_o.sck = 1'b0;
      pins_o.si = tx[i];
      tick(4);
      pins_o.sck = 1'b1;
      tick(3);
      rx[i] = so_w;
      tick(1);
    end
  endtask
  task automatic desel();
    pins_o.sck = sck_idle;
    tick(4);
    pins_o.cs_n = 1'b1;
    tick(6);
  endtask
endmodule

// ==== verif/snm_cmd_test.sv ====
// self-checking bench for the serial memory command logic
`timescale 1ns/100ps
`define CHK(a, e) begin \
  n_compared++; \
  if ((a) !== (e)) begin \
    fails++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); \
  end \
end
module snm_cmd_test;
  localparam logic [7:0] IDM = 8'h12;  // arbitrary value
  localparam logic [7:0] IDC = 8'h34;  // arbitrary value
  localparam logic [7:0] IDP1 = 8'h56; // arbitrary value
  localparam logic [7:0] IDP2 = 8'h79; // arbitrary value
  logic               clk;
  logic               rst = 1'b1;
  snm_pkg::snm_pins_t pins;
  logic               so;
  logic               oe_n;
  logic               asleep;
  logic [7:0]         rx;
  logic [7:0]         ex [2];
  int                 fails = 0;
  int                 n_compared = 0;
  int                 cyc = 0;
  time                t0;
  snm_cmd #(.ID_MAKER(IDM), .ID_CONT(IDC), .ID_PROD1(IDP1), .ID_PROD2(IDP2)) uut (
    .sys_clk_i(clk), .sys_rst_i(rst), .spi_cs_n_i(pins.cs_n), .spi_sck_i(pins.sck),
    .spi_si_i(pins.si), .spi_wp_n_i(pins.wp_n), .spi_so_o(so), .spi_so_oe_n_o(oe_n),
    .asleep_o(asleep));
  snm_host h (.sys_clk_i(clk), .so_i(so), .so_oe_n_i(oe_n), .pins_o(pins));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // long enough for every test including one full sleep recovery
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fails++;
      stop_test();
    end
  end
  function automatic logic prot(input logic [13:0] a, input logic [1:0] bp);
    return bp == 2'h3 || (bp == 2'h2 && a >= 14'h2000) || (bp == 2'h1 && a >= 14'h3000);
  endfunction
  task automatic tx(input logic [7:0] b);
    h.xfer(b, 8, rx);
  endtask
  task automatic cmd(input logic [7:0] b);
    h.sel();
    tx(b);
    h.desel();
  endtask
  task automatic chk_sr(input logic [7:0] e);
    h.sel();
    tx(snm_pkg::OP_SR_READ);
    tx(8'h3c);
    `CHK(rx, e)
    `CHK(oe_n, 1'b0)
    tx(8'hc3);
    `CHK(rx, e)
    h.desel();
    `CHK(oe_n, 1'b1)
  endtask
  task automatic wsr(input logic [7:0] d);
    h.sel();
    tx(snm_pkg::OP_SR_WRITE);
    tx(d);
    h.desel();
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d0, input logic [7:0] d1);
    h.sel();
    tx(snm_pkg::OP_MEM_WRITE);
    tx(a[15:8]);
    tx(a[7:0]);
    tx(d0);
    tx(d1);
    h.desel();
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e0, input logic [7:0] e1);
    h.sel();
    tx(snm_pkg::OP_MEM_READ);
    tx(a[15:8]);
    tx(a[7:0]);
    tx(8'h55);
    `CHK(rx, e0)
    tx(8'haa);
    `CHK(rx, e1)
    h.desel();
  endtask
  task automatic t_basic();
    chk_sr(8'h00);
    h.sel();
    h.xfer(snm_pkg::OP_SET_LATCH, 7, rx);
    h.desel();
    chk_sr(8'h00);
    h.sel();
    tx(8'hff);
    tx(snm_pkg::OP_SET_LATCH);
    h.desel();
    chk_sr(8'h00);
    wsr(8'h8c);
    chk_sr(8'h00);
    $display("t_basic done");
  endtask
  task automatic t_status();
    cmd(snm_pkg::OP_SET_LATCH);
    chk_sr(8'h02);
    wsr(8'hff);
    chk_sr(8'hfe);
    h.set_wp(1'b0);
    cmd(snm_pkg::OP_SET_LATCH);
    wsr(8'h00);
    chk_sr(8'hfe);
    h.set_wp(1'b1);
    wsr(8'h00);
    chk_sr(8'h02);
    cmd(snm_pkg::OP_CLR_LATCH);
    chk_sr(8'h00);
    $display("t_status done");
  endtask
  task automatic t_mem();
    cmd(snm_pkg::OP_SET_LATCH);
    wr(16'hffff, 8'ha1, 8'hb2);
    rd(16'h3fff, 8'ha1, 8'hb2);
    rd(16'hffff, 8'ha1, 8'hb2);
    chk_sr(8'h02);
    cmd(snm_pkg::OP_CLR_LATCH);
    wr(16'h3fff, 8'h0f, 8'hf0);
    rd(16'h3fff, 8'ha1, 8'hb2);
    $display("t_mem done");
  endtask
  task automatic t_prot();
    for (int b = 0; b < 4; b++) begin
      cmd(snm_pkg::OP_SET_LATCH);
      wsr({4'h0, 2'(b), 2'h0});
      for (int k = 0; k < 2; k++)
        if (!prot(14'h2fff + 14'(k), 2'(b))) ex[k] = 8'h40 + 8'(b);
      wr(16'h2fff, 8'h40 + 8'(b), 8'h40 + 8'(b));
      rd(16'h2fff, ex[0], ex[1]);
    end
    $display("t_prot done");
  endtask
  task automatic t_sleep();
    h.sel();
    tx(snm_pkg::OP_SLEEP);
    h.xfer(8'h80, 1, rx);
    h.desel();
    `CHK(asleep, 1'b0)
    cmd(snm_pkg::OP_SLEEP);
    `CHK(asleep, 1'b1)
    t0 = $time;
    h.sel();
    tx(snm_pkg::OP_SR_READ);
    tx(8'h00);
    `CHK(oe_n, 1'b1)
    h.desel();
    // waiting here keeps select high through recovery
    for (int k = 0; k < 5000 && asleep === 1'b1; k++) h.tick(1);
    `CHK(asleep, 1'b0)
    `CHK(($time - t0) <= 400000, 1'b1)
    $display("t_sleep done");
  endtask
  task automatic t_id();
    h.sel();
    tx(snm_pkg::OP_ID_READ);
    tx(8'hff);
    `CHK(rx, IDM)
    tx(8'h00);
    `CHK(rx, IDC)
    tx(8'hff);
    `CHK(rx, IDP1)
    tx(8'h00);
    `CHK(rx, IDP2)
    tx(8'h00);
    `CHK(rx, {8{IDP2[0]}})
    h.desel();
    $display("t_id done");
  endtask
  // mid-run reset with pins idle clears latch and status
  task automatic t_reset();
    rst = 1'b1;
    h.tick(5);
    rst = 1'b0;
    h.tick(3);
    chk_sr(8'h00);
    $display("t_reset done");
  endtask
  // clock idles high: first edge after select is a fall, last one a rise
  task automatic t_mode3();
    h.set_mode(1'b1);
    h.sel();
    tx(snm_pkg::OP_ID_READ);
    tx(8'h00);
    `CHK(rx, IDM)
    tx(8'hff);
    `CHK(rx, IDC)
    h.desel();
    `CHK(oe_n, 1'b1)
    h.set_mode(1'b0);
    $display("t_mode3 done");
  endtask
  initial begin
    h.tick(5);
    rst = 1'b0;
    h.tick(3);
    t_basic();
    t_status();
    t_mem();
    t_prot();
    t_reset();
    t_sleep();
    t_id();
    t_mode3();
    stop_test();
  end
endmodule
